/* lorg_host.sv */
// Purpose: Register port host standing in for the I2C slave side.
// Assumes: One byte per strobe, strobes one cycle long.
// Notes: Released address and data lines are inverted and strobes cleared so stale values never look valid.
`timescale 1ns/1ps
module lorg_host (
   // Clock.
   input wire logic clk_i,
   // Register port.
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   initial {addr_o, wdata_o, wr_o, rd_o} = 18'h00000;
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      {addr_o, wdata_o, wr_o, rd_o} <= {a, d, w, !w};
      @(posedge clk_i);
      {addr_o, wdata_o, wr_o, rd_o} <= {~a, ~d, 2'b00};
   endtask
endmodule

/* lorg_monitor.sv */
// Purpose: Port checker for the channel register bank.
// Assumes: One clock, reset active high.
// Notes: Bound to lorg_regs from tb.
`timescale 1ns/1ps
module lorg_monitor (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port.
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   // Comparator levels.
   input wire logic power_ok_i,
   input wire logic overvoltage_i,
   input wire logic current_limit_i,
   input wire logic undervoltage_i,
   // Regulator controls and feeds.
   input wire logic [1:0] pulldown_high_bits_i,
   input wire logic reg_one_enable_o,
   input wire logic [5:0] reg_one_voltage_code_o,
   input wire logic [11:0] reg_one_target_mv_o,
   input wire logic [3:0] buck_one_pulldown_code_o,
   input wire logic master_undervoltage_fault_o
);
   logic [7:0] wdata_d;

   // Write data of the previous cycle, so the pulldown check needs no sliced past value.
   always_ff @(posedge clk_i) begin
      wdata_d <= wdata_i;
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence stat_rd_s;
      rd_i && addr_i == 8'ha0;
   endsequence
   power_ok_a: assert property (stat_rd_s |=> rdata_o[7] == $past(power_ok_i))
      else $error("power ok bit wrong");
   ov_sticky_a: assert property (overvoltage_i ##1 stat_rd_s |=> rdata_o[6])
      else $error("overvoltage flag lost");
   ilim_sticky_a: assert property (current_limit_i ##1 stat_rd_s |=> rdata_o[5])
      else $error("current limit flag lost");
   uv_feed_a: assert property (master_undervoltage_fault_o |-> undervoltage_i)
      else $error("undervoltage feed without cause");
   target_mv_a: assert property (reg_one_target_mv_o ==
      12'h258 + 12'h032 * {6'h00, reg_one_voltage_code_o}) else $error("target wrong");
   status_rsvd_a: assert property (stat_rd_s |=> !rdata_o[4] && !rdata_o[0])
      else $error("reserved status bits set");
   pulldown_a: assert property (wr_i && addr_i == 8'ha1 |=>
      buck_one_pulldown_code_o == {pulldown_high_bits_i, wdata_d[7:6]})
      else $error("pulldown code wrong");
   direct_on_a: assert property (
      wr_i && addr_i == 8'ha2 && wdata_i[7] |=> reg_one_enable_o)
      else $error("direct enable ignored");
endmodule

/* lorg_pkg.sv */
// Purpose: Constants for the first linear regulator channel register bank.
// Assumes: Byte-wide registers reached through an I2C register port outside this bank.
// Notes: Offsets are byte addresses on the register port.
package lorg_pkg;
   localparam logic [7:0] STATUS_ADDR = 8'ha0;
   localparam logic [7:0] VOLTAGE_ADDR = 8'ha1;
   localparam logic [7:0] ENABLE_ADDR = 8'ha2;
   localparam logic [7:0] STATUS_RESET = 8'h0e;
   localparam logic [7:0] VOLTAGE_RESET = 8'h3f;
   localparam logic [7:0] ENABLE_RESET = 8'h40;
   // Status register fields.
   localparam int POWER_OK_BIT = 7;
   localparam int OV_FLAG_BIT = 6;
   localparam int ILIM_FLAG_BIT = 5;
   localparam int UV_MASK_BIT = 3;
   localparam int OV_MASK_BIT = 2;
   localparam int ILIM_MASK_BIT = 1;
   localparam logic [7:0] STATUS_WMASK = 8'h0e;
   // Voltage register fields.
   localparam int VCODE_LSB = 0;
   localparam int VCODE_W = 6;
   localparam int PDLOW_LSB = 6;
   localparam int PDLOW_W = 2;
   // Enable register fields.
   localparam int DIRECT_EN_BIT = 7;
   localparam int SLEEP_OFF_BIT = 4;
   localparam int DEEP_OFF_BIT = 3;
   // Target voltage is base plus code times step, in millivolts.
   localparam int VBASE_MV = 600;
   localparam int VSTEP_MV = 50;
   localparam int VMAX_MV = 3750;
   localparam int VMV_W = 12;
   localparam int PD_CODE_W = 4;
   // Flag state machine encodings.
   typedef enum logic [2:0] {
      LORG_FLAG_IDLE = 3'b001,
      LORG_FLAG_HELD = 3'b010,
      LORG_FLAG_CLEARABLE = 3'b100
   } lorg_flag_state_t;
endpackage

/* lorg_regs.sv */
// Purpose: Status, voltage and enable registers of the first linear regulator channel.
// Assumes: An I2C slave outside decodes bytes into one-cycle read and write strobes.
// Notes: Read data is registered and valid the cycle after the read strobe.
`timescale 1ns/1ps
module lorg_regs (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port from the I2C slave.
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic hit_o,
   // Analog comparator levels.
   input wire logic power_ok_i,
   input wire logic overvoltage_i,
   input wire logic current_limit_i,
   input wire logic undervoltage_i,
   // Sequencing, power mode and pulldown high bits.
   input wire logic seq_enable_i,
   input wire logic sleep_i,
   input wire logic deep_sleep_i,
   input wire logic [1:0] pulldown_high_bits_i,
   // Regulator controls.
   output logic reg_one_enable_o,
   output logic [5:0] reg_one_voltage_code_o,
   output logic [11:0] reg_one_target_mv_o,
   output logic [3:0] buck_one_pulldown_code_o,
   output logic [2:0] reg_one_sequence_qualifier_o,
   output logic reg_one_pushbutton_seq_enable_o,
   // Fault and interrupt feeds to the master logic.
   output logic master_undervoltage_fault_o,
   output logic master_overvoltage_fault_o,
   output logic current_limit_irq_o
);
   logic [7:0] mask_reg;
   logic [7:0] mask_next;
   logic [7:0] vset_reg;
   logic [7:0] vset_next;
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [7:0] status_view;
   logic reg_one_overvoltage_flag;
   logic reg_one_current_limit_flag;
   logic status_read;

   function automatic logic sel(input logic [7:0] a, input logic [7:0] b);
      sel = (a == b);
   endfunction

   assign status_read = rd_i && sel(addr_i, lorg_pkg::STATUS_ADDR);

   lorg_sticky_flag u_ov_flag (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cause_i(overvoltage_i),
      .read_i(status_read),
      .flag_o(reg_one_overvoltage_flag)
   );

   lorg_sticky_flag u_ilim_flag (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cause_i(current_limit_i),
      .read_i(status_read),
      .flag_o(reg_one_current_limit_flag)
   );

   always_comb begin
      status_view = mask_reg & lorg_pkg::STATUS_WMASK;
      status_view[lorg_pkg::POWER_OK_BIT] = power_ok_i;
      status_view[lorg_pkg::OV_FLAG_BIT] = reg_one_overvoltage_flag;
      status_view[lorg_pkg::ILIM_FLAG_BIT] = reg_one_current_limit_flag;
   end

   // Only the mask bits of the status byte take writes; the other bytes are fully writable,
   // reserved bits included, so software keeps them by writing back what it read.
   always_comb begin
      mask_next = mask_reg;
      vset_next = vset_reg;
      ctrl_next = ctrl_reg;
      rdata_next = rdata_reg;
      if (wr_i && sel(addr_i, lorg_pkg::STATUS_ADDR)) begin
         mask_next = wdata_i & lorg_pkg::STATUS_WMASK;
      end
      if (wr_i && sel(addr_i, lorg_pkg::VOLTAGE_ADDR)) begin
         vset_next = wdata_i;
      end
      if (wr_i && sel(addr_i, lorg_pkg::ENABLE_ADDR)) begin
         ctrl_next = wdata_i;
      end
      if (rd_i) begin
         case (addr_i)
            lorg_pkg::STATUS_ADDR: rdata_next = status_view;
            lorg_pkg::VOLTAGE_ADDR: rdata_next = vset_reg;
            lorg_pkg::ENABLE_ADDR: rdata_next = ctrl_reg;
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mask_reg <= lorg_pkg::STATUS_RESET;
         vset_reg <= lorg_pkg::VOLTAGE_RESET;
         ctrl_reg <= lorg_pkg::ENABLE_RESET;
         rdata_reg <= 8'h00;
      end else begin
         mask_reg <= mask_next;
         vset_reg <= vset_next;
         ctrl_reg <= ctrl_next;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_o = rdata_reg;
   assign hit_o = sel(addr_i, lorg_pkg::STATUS_ADDR) || sel(addr_i, lorg_pkg::VOLTAGE_ADDR)
      || sel(addr_i, lorg_pkg::ENABLE_ADDR);

   // Masks gate only the master feeds; the local overvoltage and current limit flags keep reporting.
   assign master_undervoltage_fault_o = undervoltage_i
      && !mask_reg[lorg_pkg::UV_MASK_BIT];
   assign master_overvoltage_fault_o = reg_one_overvoltage_flag
      && !mask_reg[lorg_pkg::OV_MASK_BIT];
   assign current_limit_irq_o = reg_one_current_limit_flag
      && !mask_reg[lorg_pkg::ILIM_MASK_BIT];

   // Sleep states override sequencing when their off bits are set, but the direct enable wins over everything.
   assign reg_one_enable_o = ctrl_reg[lorg_pkg::DIRECT_EN_BIT]
      || (seq_enable_i
      && !(sleep_i && ctrl_reg[lorg_pkg::SLEEP_OFF_BIT])
      && !(deep_sleep_i && ctrl_reg[lorg_pkg::DEEP_OFF_BIT]));

   assign reg_one_voltage_code_o = vset_reg[lorg_pkg::VCODE_LSB +: lorg_pkg::VCODE_W];
   assign reg_one_target_mv_o = 12'(lorg_pkg::VBASE_MV)
      + 12'(lorg_pkg::VSTEP_MV) * {6'h00, reg_one_voltage_code_o};
   assign buck_one_pulldown_code_o = {pulldown_high_bits_i,
      vset_reg[lorg_pkg::PDLOW_LSB +: lorg_pkg::PDLOW_W]};
   // Factory sequencing fields are passed on untouched; software is trusted to leave them.
   assign reg_one_sequence_qualifier_o = ctrl_reg[2:0];
   assign reg_one_pushbutton_seq_enable_o = ctrl_reg[6];
endmodule

/* lorg_sticky_flag.sv */
// Purpose: Sticky event flag that clears only once the cause is gone and the flag was read.
// Assumes: Cause and read strobe are synchronous to clk_i.
// Notes: A cause present in the read cycle keeps the flag set.
`timescale 1ns/1ps
module lorg_sticky_flag (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Event and clear qualifiers.
   input wire logic cause_i,
   input wire logic read_i,
   // Flag.
   output logic flag_o
);
   lorg_pkg::lorg_flag_state_t state_reg;
   lorg_pkg::lorg_flag_state_t state_next;

   // A read taken while the cause still stands arms the clear, so the flag drops as soon as
   // the cause goes; a new cause always wins over a pending clear.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         lorg_pkg::LORG_FLAG_IDLE: begin
            if (cause_i) begin
               state_next = lorg_pkg::LORG_FLAG_HELD;
            end
         end
         lorg_pkg::LORG_FLAG_HELD: begin
            if (read_i && !cause_i) begin
               state_next = lorg_pkg::LORG_FLAG_IDLE;
            end else if (read_i) begin
               state_next = lorg_pkg::LORG_FLAG_CLEARABLE;
            end
         end
         lorg_pkg::LORG_FLAG_CLEARABLE: begin
            if (!cause_i) begin
               state_next = lorg_pkg::LORG_FLAG_IDLE;
            end
         end
         default: begin
            state_next = lorg_pkg::LORG_FLAG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= lorg_pkg::LORG_FLAG_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign flag_o = (state_reg != lorg_pkg::LORG_FLAG_IDLE);
endmodule

/* tb.sv */
// Purpose: Self-checking bench for lorg_regs.
// Assumes: Host model issues one strobe at a time.
// Notes: Read data is queued and compared the cycle after the strobe is taken.
`timescale 1ns/1ps
module tb;
   logic clk_i = 1'b0, rst_i = 1'b1, pok = 1'b0, uv = 1'b0, seq = 1'b0, slp = 1'b0, dslp = 1'b0;
   logic wr, rd, hit, en, muv, mov, irq, pbe, rd_d = 1'b0;
   logic [2:0] sq;
   logic [1:0] flt = 2'h0, pdh = 2'h0;
   logic [7:0] addr, wdata, rdata, d;
   logic [5:0] vcode;
   logic [11:0] tmv, exq[$];
   logic [3:0] pdc;
   logic [31:0] rnd = 32'h172f1fb6;
   // Each entry: control byte, then sequencing, sleep and deep-sleep levels, then expected enable.
   logic [11:0] tbl[8] = '{12'hc01, 12'h40b, 12'h400, 12'h50c, 12'h40d, 12'h48a, 12'h48d, 12'hd8f};
   int err_total = 0, total_checks = 0;
   initial forever #12.5 clk_i = ~clk_i;
   lorg_host i_host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
   lorg_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .hit_o(hit), .power_ok_i(pok), .overvoltage_i(flt[1]),
      .current_limit_i(flt[0]), .undervoltage_i(uv), .seq_enable_i(seq), .sleep_i(slp),
      .deep_sleep_i(dslp), .pulldown_high_bits_i(pdh), .reg_one_enable_o(en),
      .reg_one_voltage_code_o(vcode), .reg_one_target_mv_o(tmv), .buck_one_pulldown_code_o(pdc),
      .reg_one_sequence_qualifier_o(sq), .reg_one_pushbutton_seq_enable_o(pbe),
      .master_undervoltage_fault_o(muv), .master_overvoltage_fault_o(mov),
      .current_limit_irq_o(irq));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string n, input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
      exq.push_back({4'h0, e});
      i_host.xfer(1'b0, a, 8'h00);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      if (rd_d) chk("rdata", {4'h0, rdata}, exq.pop_front());
      if (rd) chk("hit", {11'h000, hit}, {11'h000, addr inside {8'ha0, 8'ha1, 8'ha2}});
      rd_d <= rd;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      chk("timeout", 12'h001, 12'h000);
      stop_test;
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_exp(8'ha0, 8'h0e);
      rd_exp(8'ha1, 8'h3f);
      rd_exp(8'ha2, 8'h40);
      rd_exp(8'ha3, 8'h00);
      i_host.xfer(1'b1, 8'ha0, 8'hee);
      rd_exp(8'ha0, 8'h0e);
      i_host.xfer(1'b1, 8'ha0, 8'h00);
      {pok, uv} <= 2'b11;
      rd_exp(8'ha0, 8'h80);
      #1 chk("uv feed", {11'h000, muv}, 12'h001);
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_i);
         flt[1 - k] <= 1'b1;
         repeat (2) @(posedge clk_i);
         flt <= 2'b00;
         // Flag must outlive its cause until a status read sees it.
         repeat (3) @(posedge clk_i);
         #1 chk("fault feed", {11'h000, k ? irq : mov}, 12'h001);
         rd_exp(8'ha0, 8'h80 | (8'h40 >> k));
         rd_exp(8'ha0, 8'h80);
      end
      i_host.xfer(1'b1, 8'ha0, 8'h0e);
      flt <= 2'b11;
      repeat (2) @(posedge clk_i);
      #1 chk("masked feeds", {9'h000, muv, mov, irq}, 12'h000);
      rd_exp(8'ha0, 8'hee);
      flt <= 2'b00;
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_i);
         rnd = lfsr(rnd);
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd[7:0];
         pdh <= rnd[9:8];
         i_host.xfer(1'b1, 8'ha1, d);
         rd_exp(8'ha1, d);
         #1 chk("target", tmv, 12'h258 + 12'h032 * {6'h00, d[5:0]});
         chk("pulldown", {8'h00, pdc}, {8'h00, rnd[9:8], d[7:6]});
         chk("vcode", {6'h00, vcode}, {6'h00, d[5:0]});
      end
      foreach (tbl[j]) begin
         @(posedge clk_i);
         {seq, slp, dslp} <= tbl[j][3:1];
         i_host.xfer(1'b1, 8'ha2, tbl[j][11:4]);
         #1 chk("enable", {11'h000, en}, {11'h000, tbl[j][0]});
         chk("factory", {8'h00, pbe, sq}, {8'h00, tbl[j][10], tbl[j][6:4]});
      end
      rd_exp(8'ha2, 8'hd8);
      repeat (3) @(posedge clk_i);
      stop_test;
   end
endmodule
bind lorg_regs lorg_monitor i_mon (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .addr_i(addr_i),
   .wdata_i(wdata_i),
   .wr_i(wr_i),
   .rd_i(rd_i),
   .rdata_o(rdata_o),
   .power_ok_i(power_ok_i),
   .overvoltage_i(overvoltage_i),
   .current_limit_i(current_limit_i),
   .undervoltage_i(undervoltage_i),
   .pulldown_high_bits_i(pulldown_high_bits_i),
   .reg_one_enable_o(reg_one_enable_o),
   .reg_one_voltage_code_o(reg_one_voltage_code_o),
   .reg_one_target_mv_o(reg_one_target_mv_o),
   .buck_one_pulldown_code_o(buck_one_pulldown_code_o),
   .master_undervoltage_fault_o(master_undervoltage_fault_o)
);
